// ===== core/qec_pkg.sv
package qec_pkg;

  // ---------------------------------------------------------------
  // Register map (16-bit registers, address in bytes)
  // ---------------------------------------------------------------
  localparam int           ADDR_W          = 16;
  localparam int           DATA_W          = 16;
  localparam logic [15:0]  ADDR_CTRL       = 16'h0122;
  localparam logic [15:0]  ADDR_FILT       = 16'h0124;
  localparam logic [15:0]  ADDR_POS        = 16'h0126;
  localparam logic [15:0]  ADDR_MAX        = 16'h0128;
  localparam logic [15:0]  ADDR_STAT       = 16'h012A;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int           CTRL_ERR        = 15;
  localparam int           CTRL_IDLE_STOP  = 13;
  localparam int           CTRL_IDX_STATE  = 12;
  localparam int           CTRL_DIR        = 11;
  localparam int           CTRL_MODE_LO    = 8;
  localparam int           CTRL_DIR_OE     = 6;
  localparam int           CTRL_IDX_RST    = 2;
  localparam int           CTRL_TIMER_DIRECTION_SOURCE      = 0;
  localparam int           FILT_COUNT_ERROR_IRQ_DISABLE       = 8;
  localparam int           FILT_OUT_EN     = 7;
  localparam int           FILT_CK_LO      = 4;
  localparam int           STAT_IRQ        = 0;

  // ---------------------------------------------------------------
  // Operating modes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0]   MODE_TIMER      = 3'h1;
  localparam logic [2:0]   MODE_X2_IDX     = 3'h4;
  localparam logic [2:0]   MODE_X2_MAX     = 3'h5;
  localparam logic [2:0]   MODE_X4_IDX     = 3'h6;
  localparam logic [2:0]   MODE_X4_MAX     = 3'h7;
  localparam logic [15:0]  MAXC_RST        = 16'hFFFF;
  localparam logic [15:0]  ERR_DOWN_VALUE  = 16'hFFFF;
  localparam int           DIV_W           = 7;

endpackage : qec_pkg

// ===== core/qec_encoder_interface.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - A leading B counts forward
// - 16-bit counter steps one per pulse
// - Index modes flag count error on limit
// - Filter bit 8 suppresses error interrupt
// - After error keep counting, wrap silently
// - Error flag sticky until software clears
// - Index clears counter when index reset set
// - Index interrupt always, never on wrap
// - Direction status bit, pin when enabled
// - x2 modes count phase A edges only
// - x4 modes count both phase edges
// - Modes 100/110 index reset, 101/111 max
// - Filter output needs three equal samples
// - Filter clock divided by filter bits 6:4
// - Filters bypassed until output enable set
// - Timer mode counts phase A rising edges
// - Timer period match sets interrupt flag
// - Timer direction from phase B or bit
// - Mode change keeps count value
// - Timer clock sampled on system clock
// - Sleep halts counting and timer
// - Single sticky interrupt flag, software clears
// - Idle halts only when idle-stop set
module qec_encoder_interface
  import qec_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic                    sys_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic [qec_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [qec_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [qec_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic                    phase_a_input_i,
  input  wire logic                    phase_b_input_i,
  input  wire logic                    index_input_i,
  input  wire logic                    cpu_sleep_i,
  input  wire logic                    cpu_idle_i,
  output logic                         count_direction_o,
  output logic                         count_direction_oe_n_o,
  output logic                         module_interrupt_flag_o
);
  import qec_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic [1:0]       hist_a;
    logic [1:0]       hist_b;
    logic [1:0]       hist_i;
    logic             filt_a;
    logic             filt_b;
    logic             filt_i;
    logic             prev_a;
    logic             prev_b;
    logic             prev_i;
    logic [CNT_W-1:0] pos;
    logic [CNT_W-1:0] maxc;
    logic             err;
    logic             irq;
    logic             idle_stop;
    logic             dir;
    logic [2:0]       mode;
    logic             dir_oe;
    logic             idx_rst;
    logic             timer_direction_source;
    logic             count_error_irq_disable;
    logic             filt_out;
    logic [2:0]       ck_div;
    logic [DATA_W-1:0] rdata;
  } qec_state_t;

  qec_state_t q_ff;
  qec_state_t nxt_q;

  function automatic logic [DIV_W-1:0] qec_div_mask(input logic [2:0] sel);
    logic [DIV_W:0] one_hot;
    one_hot = (DIV_W+1)'(1) << sel;
    return DIV_W'(one_hot - (DIV_W+1)'(1));
  endfunction : qec_div_mask

  function automatic logic qec_is_idx_mode(input logic [2:0] m);
    return (m == MODE_X2_IDX) || (m == MODE_X4_IDX);
  endfunction : qec_is_idx_mode

  function automatic logic qec_is_max_mode(input logic [2:0] m);
    return (m == MODE_X2_MAX) || (m == MODE_X4_MAX);
  endfunction : qec_is_max_mode

  // ---------------------------------------------------------------
  // Input conditioning and edge decode
  // ---------------------------------------------------------------
  logic             run;
  logic             tick;
  logic             sel_a;
  logic             sel_b;
  logic             sel_i;
  logic             a_chg;
  logic             b_chg;
  logic             enc_pulse;
  logic             enc_up;
  logic             idx_evt;
  logic             tmr_pulse;
  logic             tmr_up;
  logic             wr_ctrl;
  logic             wr_filt;
  logic             wr_pos;
  logic             wr_max;
  logic             wr_stat;

  assign run   = !cpu_sleep_i && !(cpu_idle_i && q_ff.idle_stop);
  assign tick  = (q_ff.div_cnt & qec_div_mask(q_ff.ck_div)) == '0;
  assign sel_a = q_ff.filt_out ? q_ff.filt_a : phase_a_input_i;
  assign sel_b = q_ff.filt_out ? q_ff.filt_b : phase_b_input_i;
  assign sel_i = q_ff.filt_out ? q_ff.filt_i : index_input_i;
  // Simultaneous change of both phases is illegal and counted in neither x2 nor x4 mode
  assign a_chg = sel_a ^ q_ff.prev_a;
  assign b_chg = sel_b ^ q_ff.prev_b;
  assign enc_pulse = q_ff.mode[1] ? (a_chg ^ b_chg) : (a_chg && !b_chg);
  assign enc_up    = sel_a ^ q_ff.prev_b;
  // Index qualified with both phases low; relies on the encoder timing
  assign idx_evt   = sel_i && !q_ff.prev_i && !sel_a && !sel_b;
  assign tmr_pulse = sel_a && !q_ff.prev_a;
  assign tmr_up    = q_ff.timer_direction_source ? sel_b : q_ff.dir;

  assign wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
  assign wr_filt = wr_i && (addr_i == ADDR_FILT);
  assign wr_pos  = wr_i && (addr_i == ADDR_POS);
  assign wr_max  = wr_i && (addr_i == ADDR_MAX);
  assign wr_stat = wr_i && (addr_i == ADDR_STAT);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic             err_set;
    logic             irq_set;
    logic [CNT_W-1:0] stepped;
    logic [DATA_W-1:0] rv;
    nxt_q   = q_ff;
    err_set = 1'b0;
    irq_set = 1'b0;
    stepped = q_ff.pos;
    rv      = '0;

    if (run)
    begin
      nxt_q.div_cnt = q_ff.div_cnt + DIV_W'(1);
      nxt_q.prev_a  = sel_a;
      nxt_q.prev_b  = sel_b;
      nxt_q.prev_i  = sel_i;
      if (tick)
      begin
        // Three samples: two held plus the present one
        nxt_q.hist_a = {q_ff.hist_a[0], phase_a_input_i};
        nxt_q.hist_b = {q_ff.hist_b[0], phase_b_input_i};
        nxt_q.hist_i = {q_ff.hist_i[0], index_input_i};
        if (q_ff.hist_a == {2{phase_a_input_i}})
          nxt_q.filt_a = phase_a_input_i;
        if (q_ff.hist_b == {2{phase_b_input_i}})
          nxt_q.filt_b = phase_b_input_i;
        if (q_ff.hist_i == {2{index_input_i}})
          nxt_q.filt_i = index_input_i;
      end

      if (q_ff.mode == MODE_TIMER)
      begin
        if (tmr_pulse)
        begin
          if (tmr_up)
          begin
            if (q_ff.pos == q_ff.maxc)
            begin
              nxt_q.pos = '0;
              irq_set   = 1'b1;
            end
            else
              nxt_q.pos = q_ff.pos + CNT_W'(1);
          end
          else if (q_ff.pos == '0)
          begin
            nxt_q.pos = q_ff.maxc;
            irq_set   = 1'b1;
          end
          else
            nxt_q.pos = q_ff.pos - CNT_W'(1);
        end
      end
      else if (qec_is_idx_mode(q_ff.mode))
      begin
        if (enc_pulse)
        begin
          nxt_q.dir = enc_up;
          stepped   = enc_up ? q_ff.pos + CNT_W'(1) : q_ff.pos - CNT_W'(1);
          nxt_q.pos = stepped;
          if (stepped == (enc_up ? q_ff.maxc + CNT_W'(1) : ERR_DOWN_VALUE))
          begin
            err_set = 1'b1;
            irq_set = !q_ff.count_error_irq_disable;
          end
        end
        if (idx_evt)
        begin
          irq_set = 1'b1;
          if (q_ff.idx_rst)
            nxt_q.pos = '0;
        end
      end
      else if (qec_is_max_mode(q_ff.mode))
      begin
        if (enc_pulse)
        begin
          nxt_q.dir = enc_up;
          if (enc_up && (q_ff.pos == q_ff.maxc))
          begin
            nxt_q.pos = '0;
            irq_set   = 1'b1;
          end
          else if (!enc_up && (q_ff.pos == '0))
          begin
            nxt_q.pos = q_ff.maxc;
            irq_set   = 1'b1;
          end
          else
            nxt_q.pos = enc_up ? q_ff.pos + CNT_W'(1) : q_ff.pos - CNT_W'(1);
        end
      end
    end

    // Software writes win over counting; mode writes leave the count alone
    if (wr_ctrl)
    begin
      nxt_q.err       = wr_data_i[CTRL_ERR];
      nxt_q.idle_stop = wr_data_i[CTRL_IDLE_STOP];
      nxt_q.mode      = wr_data_i[CTRL_MODE_LO +: 3];
      nxt_q.dir_oe    = wr_data_i[CTRL_DIR_OE];
      nxt_q.idx_rst   = wr_data_i[CTRL_IDX_RST];
      nxt_q.timer_direction_source     = wr_data_i[CTRL_TIMER_DIRECTION_SOURCE];
      if (q_ff.mode == MODE_TIMER)
        nxt_q.dir = wr_data_i[CTRL_DIR];
    end
    if (wr_filt)
    begin
      nxt_q.count_error_irq_disable     = wr_data_i[FILT_COUNT_ERROR_IRQ_DISABLE];
      nxt_q.filt_out = wr_data_i[FILT_OUT_EN];
      nxt_q.ck_div   = wr_data_i[FILT_CK_LO +: 3];
    end
    if (wr_pos)
      nxt_q.pos = CNT_W'(wr_data_i);
    if (wr_max)
      nxt_q.maxc = CNT_W'(wr_data_i);
    if (wr_stat && wr_data_i[STAT_IRQ])
      nxt_q.irq = 1'b0;
    // Hardware set beats a clear in the same cycle
    nxt_q.err = nxt_q.err || err_set;
    nxt_q.irq = nxt_q.irq || irq_set;

    rv = '0;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CTRL:
        begin
          rv[CTRL_ERR]            = q_ff.err;
          rv[CTRL_IDLE_STOP]      = q_ff.idle_stop;
          rv[CTRL_IDX_STATE]      = sel_i;
          rv[CTRL_DIR]            = q_ff.dir;
          rv[CTRL_MODE_LO +: 3]   = q_ff.mode;
          rv[CTRL_DIR_OE]         = q_ff.dir_oe;
          rv[CTRL_IDX_RST]        = q_ff.idx_rst;
          rv[CTRL_TIMER_DIRECTION_SOURCE]          = q_ff.timer_direction_source;
        end
        ADDR_FILT:
        begin
          rv[FILT_COUNT_ERROR_IRQ_DISABLE]           = q_ff.count_error_irq_disable;
          rv[FILT_OUT_EN]         = q_ff.filt_out;
          rv[FILT_CK_LO +: 3]     = q_ff.ck_div;
        end
        ADDR_POS:  rv = DATA_W'(q_ff.pos);
        ADDR_MAX:  rv = DATA_W'(q_ff.maxc);
        ADDR_STAT: rv[STAT_IRQ]  = q_ff.irq;
        default:   rv = '0;
      endcase
    end
    nxt_q.rdata = rv;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      q_ff      <= '0;
      q_ff.maxc <= CNT_W'(MAXC_RST);
    end
    else
      q_ff <= nxt_q;
  end

  assign rd_data_o               = q_ff.rdata;
  assign count_direction_o       = q_ff.dir;
  assign count_direction_oe_n_o  = !q_ff.dir_oe;
  assign module_interrupt_flag_o = q_ff.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  logic no_sw;
  assign no_sw = !wr_pos && !wr_ctrl;

  sequence s_x4_fwd_step;
    run && q_ff.mode == MODE_X4_MAX && enc_pulse && enc_up && no_sw
      && q_ff.pos != q_ff.maxc;
  endsequence

  sequence s_idx_clear;
    run && qec_is_idx_mode(q_ff.mode) && q_ff.idx_rst && idx_evt && !wr_pos;
  endsequence

  property p_fwd_step;
    s_x4_fwd_step |=> q_ff.pos == $past(q_ff.pos) + CNT_W'(1) && q_ff.dir;
  endproperty
  a_fwd_step: assert property (p_fwd_step) else $error("forward step wrong");

  property p_idx_clear;
    s_idx_clear |=> q_ff.pos == '0 && q_ff.irq;
  endproperty
  a_idx_clear: assert property (p_idx_clear) else $error("index clear wrong");

  property p_err_sticky;
    q_ff.err && !(wr_ctrl && !wr_data_i[CTRL_ERR]) |=> q_ff.err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

  property p_err_set;
    run && qec_is_idx_mode(q_ff.mode) && enc_pulse && !enc_up && q_ff.pos == '0 && no_sw
      && !q_ff.count_error_irq_disable && !wr_stat |=> q_ff.err && q_ff.irq && q_ff.pos == ERR_DOWN_VALUE;
  endproperty
  a_err_set: assert property (p_err_set) else $error("count error missed");

  property p_count_error_irq_disable_quiet;
    run && qec_is_idx_mode(q_ff.mode) && q_ff.count_error_irq_disable && !idx_evt && !q_ff.irq
      && !wr_i |=> !q_ff.irq;
  endproperty
  a_count_error_irq_disable_quiet: assert property (p_count_error_irq_disable_quiet) else $error("error irq not masked");

  property p_x2_ignores_b;
    run && q_ff.mode == MODE_X2_MAX && !a_chg && b_chg && no_sw |=> $stable(q_ff.pos);
  endproperty
  a_x2_ignores_b: assert property (p_x2_ignores_b) else $error("x2 counted phase B");

  property p_max_wrap;
    run && qec_is_max_mode(q_ff.mode) && enc_pulse && enc_up && q_ff.pos == q_ff.maxc
      && no_sw && !wr_stat |=> q_ff.pos == '0 && q_ff.irq;
  endproperty
  a_max_wrap: assert property (p_max_wrap) else $error("max wrap wrong");

  property p_timer_match;
    run && q_ff.mode == MODE_TIMER && tmr_pulse && tmr_up && q_ff.pos == q_ff.maxc
      && no_sw && !wr_stat |=> q_ff.pos == '0 && q_ff.irq;
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("period match missed");

  property p_sleep_hold;
    (cpu_sleep_i && !wr_pos) [*2] |-> $stable(q_ff.pos);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  property p_filter_three;
    run && $changed(q_ff.filt_a) |-> $past(q_ff.hist_a) == {2{q_ff.filt_a}} && $past(tick);
  endproperty
  a_filter_three: assert property (p_filter_three) else $error("filter changed early");

  property p_dir_pin;
    rd_i && !wr_i && addr_i == ADDR_CTRL |=> rd_data_o[CTRL_DIR] == $past(count_direction_o)
      && count_direction_oe_n_o == !rd_data_o[CTRL_DIR_OE];
  endproperty
  a_dir_pin: assert property (p_dir_pin) else $error("direction pin wrong");

endmodule : qec_encoder_interface

// ===== test/qec_encoder_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Encoder model: two phases and index, levels change after an edge
// ---------------------------------------------------------------
module qec_encoder_model (
  input  wire logic clk_i,
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  logic [1:0] st_ff;

  initial
  begin
    st_ff = 2'h0;
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
    index_o = 1'b0;
  end

  // Forward walk 00,10,11,01: A leads B
  task automatic step(input logic fwd, input int hold);
    @(posedge clk_i);
    st_ff = fwd ? st_ff + 2'h1 : st_ff - 2'h1;
    phase_a_o <= (st_ff == 2'h1) || (st_ff == 2'h2);
    phase_b_o <= (st_ff == 2'h2) || (st_ff == 2'h3);
    repeat (hold) @(posedge clk_i);
  endtask : step

  task automatic home(input int hold);
    while (st_ff != 2'h0)
      step(1'b1, hold);
  endtask : home

  // Index only while both phases sit low
  task automatic index_pulse(input int hold);
    home(hold);
    @(posedge clk_i);
    index_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    index_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
  endtask : index_pulse

  // Short spike on phase A, then back to the old level
  task automatic glitch(input int len);
    @(posedge clk_i);
    phase_a_o <= ~phase_a_o;
    repeat (len) @(posedge clk_i);
    phase_a_o <= ~phase_a_o;
    repeat (len + 12) @(posedge clk_i);
  endtask : glitch
endmodule : qec_encoder_model

// ===== test/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  import qec_pkg::*;
  localparam int H = 6;
  logic        sys_clk_i, nrst_i, wr_i, rd_i, cpu_sleep_i, cpu_idle_i;
  logic [15:0] addr_i, wr_data_i, rd_data_o, exp_v, n, r;
  logic        dir, dir_oe_n, irq, ph_a, ph_b, idx, rd_pend;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int          n_fail, checked;

  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  qec_encoder_interface dut_u (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .phase_a_input_i(ph_a),
    .phase_b_input_i(ph_b), .index_input_i(idx), .cpu_sleep_i(cpu_sleep_i),
    .cpu_idle_i(cpu_idle_i), .count_direction_o(dir), .count_direction_oe_n_o(dir_oe_n),
    .module_interrupt_flag_o(irq));

  qec_encoder_model enc_u (.clk_i(sys_clk_i), .phase_a_o(ph_a), .phase_b_o(ph_b), .index_o(idx));

  // ---------------------------------------------------------------
  // Read data watcher: read data stands only one cycle after rd_i
  // ---------------------------------------------------------------
  always @(posedge sys_clk_i) rd_pend <= rd_i;
  always @(negedge sys_clk_i)
    if (rd_pend && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK(rd_data_o, exp_v)
    end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : rd

  task automatic conclude();
    $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // Run needs well under 5000 cycles
  initial
  begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end

  initial
  begin
    nrst_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 16'h0000; wr_data_i = 16'h0000;
    cpu_sleep_i = 1'b0; cpu_idle_i = 1'b0; n_fail = 0; checked = 0;
    seed = 32'h76b5;
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(ADDR_CTRL, 16'h0000);
    rd(ADDR_FILT, 16'h0000);
    rd(ADDR_POS, 16'h0000);
    rd(ADDR_MAX, MAXC_RST);
    rd(ADDR_STAT, 16'h0000);
    wr(16'h0130, 16'h1234);
    rd(16'h0130, 16'h0000);
    $display("test reset done");
    seed = lfsr(seed);
    n = {13'h0, seed[2:0]} + 16'h2;
    wr(ADDR_CTRL, 16'h0740);
    repeat (n) enc_u.step(1'b1, H);
    @(negedge sys_clk_i);
    `CHK(dir, 1'b1)
    `CHK(dir_oe_n, 1'b0)
    rd(ADDR_POS, n);
    rd(ADDR_CTRL, 16'h0F40);
    repeat (2) enc_u.step(1'b0, H);
    rd(ADDR_POS, n - 16'h2);
    rd(ADDR_CTRL, 16'h0740);
    wr(ADDR_CTRL, 16'h0700);
    @(negedge sys_clk_i);
    `CHK(dir_oe_n, 1'b1)
    $display("test x4 count done");
    wr(ADDR_MAX, 16'h0003);
    wr(ADDR_POS, 16'h0003);
    enc_u.step(1'b1, H);
    rd(ADDR_POS, 16'h0000);
    rd(ADDR_STAT, 16'h0001);
    @(negedge sys_clk_i);
    `CHK(irq, 1'b1)
    wr(ADDR_STAT, 16'h0001);
    rd(ADDR_STAT, 16'h0000);
    enc_u.step(1'b0, H);
    rd(ADDR_POS, 16'h0003);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    $display("test max wrap done");
    wr(ADDR_MAX, 16'hFFFF);
    wr(ADDR_POS, 16'h0000);
    wr(ADDR_CTRL, 16'h0500);
    repeat (4) enc_u.step(1'b1, H);
    rd(ADDR_POS, 16'h0002);
    $display("test x2 count done");
    wr(ADDR_CTRL, 16'h0604);
    enc_u.home(H);
    wr(ADDR_POS, 16'h0005);
    enc_u.index_pulse(H);
    rd(ADDR_POS, 16'h0000);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    wr(ADDR_CTRL, 16'h0600);
    wr(ADDR_POS, 16'h0005);
    enc_u.index_pulse(H);
    rd(ADDR_POS, 16'h0005);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    $display("test index done");
    wr(ADDR_MAX, 16'h0003);
    wr(ADDR_POS, 16'h0003);
    enc_u.step(1'b1, H);
    rd(ADDR_POS, 16'h0004);
    rd(ADDR_CTRL, 16'h8E00);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    enc_u.step(1'b1, H);
    rd(ADDR_POS, 16'h0005);
    rd(ADDR_STAT, 16'h0000);
    rd(ADDR_CTRL, 16'h8E00);
    wr(ADDR_CTRL, 16'h0600);
    rd(ADDR_CTRL, 16'h0E00);
    wr(ADDR_FILT, 16'h0100);
    wr(ADDR_POS, 16'h0003);
    enc_u.step(1'b1, H);
    rd(ADDR_CTRL, 16'h8E00);
    rd(ADDR_STAT, 16'h0000);
    wr(ADDR_FILT, 16'h0000);
    wr(ADDR_CTRL, 16'h0400);
    wr(ADDR_POS, 16'h0000);
    enc_u.step(1'b0, H);
    rd(ADDR_POS, 16'hFFFF);
    rd(ADDR_CTRL, 16'h8400);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    $display("test count error done");
    wr(ADDR_MAX, 16'hFFFF);
    wr(ADDR_CTRL, 16'h2700);
    wr(ADDR_POS, 16'h0000);
    cpu_sleep_i <= 1'b1;
    repeat (2) enc_u.step(1'b1, H);
    repeat (2) enc_u.step(1'b0, H);
    cpu_sleep_i <= 1'b0;
    rd(ADDR_POS, 16'h0000);
    cpu_idle_i <= 1'b1;
    repeat (2) enc_u.step(1'b1, H);
    repeat (2) enc_u.step(1'b0, H);
    rd(ADDR_POS, 16'h0000);
    wr(ADDR_CTRL, 16'h0700);
    repeat (2) enc_u.step(1'b1, H);
    rd(ADDR_POS, 16'h0002);
    cpu_idle_i <= 1'b0;
    $display("test sleep idle done");
    seed = lfsr(seed);
    r = {8'h00, seed[7:1], 1'b1};
    wr(ADDR_POS, r);
    wr(ADDR_CTRL, 16'h0900);
    wr(ADDR_CTRL, 16'h0900);
    rd(ADDR_POS, r);
    wr(ADDR_MAX, 16'h0100);
    repeat (4) enc_u.step(1'b1, H);
    rd(ADDR_POS, r + 16'h1);
    wr(ADDR_POS, 16'h0100);
    repeat (4) enc_u.step(1'b1, H);
    rd(ADDR_POS, 16'h0000);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    wr(ADDR_POS, r);
    wr(ADDR_CTRL, 16'h0100);
    repeat (4) enc_u.step(1'b1, H);
    rd(ADDR_POS, r - 16'h1);
    wr(ADDR_CTRL, 16'h0101);
    repeat (4) enc_u.step(1'b0, H);
    rd(ADDR_POS, r);
    repeat (4) enc_u.step(1'b1, H);
    rd(ADDR_POS, r - 16'h1);
    wr(ADDR_CTRL, 16'h0700);
    rd(ADDR_POS, r - 16'h1);
    $display("test timer done");
    wr(ADDR_MAX, 16'hFFFF);
    enc_u.home(H);
    wr(ADDR_POS, 16'h0000);
    wr(ADDR_FILT, 16'h0080);
    enc_u.glitch(1);
    rd(ADDR_POS, 16'h0000);
    enc_u.step(1'b1, 0);
    rd(ADDR_POS, 16'h0000);
    rd(ADDR_POS, 16'h0001);
    wr(ADDR_FILT, 16'h00B0);
    enc_u.glitch(10);
    rd(ADDR_POS, 16'h0001);
    enc_u.step(1'b1, 12);
    rd(ADDR_POS, 16'h0001);
    repeat (12) @(posedge sys_clk_i);
    rd(ADDR_POS, 16'h0002);
    $display("test filter done");
    repeat (4) @(posedge sys_clk_i);
    conclude();
  end
endmodule : tb
